// ---- logic/npd_map.vh ----
`ifndef NPD_MAP_VH
`define NPD_MAP_VH

// Acknowledgement framing
`define NPD_ACK_ID          8'h00
`define NPD_ACK_LEN         8'h04
`define NPD_ACK_BYTES       3'h6
`define NPD_ACK_LAST_IDX    3'h5

// Emitted byte positions of one acknowledgement
`define NPD_EB_ID           3'h0
`define NPD_EB_LEN          3'h1
`define NPD_EB_ECHO_ID      3'h2
`define NPD_EB_CRC_LO       3'h3
`define NPD_EB_CRC_HI       3'h4
`define NPD_EB_CODE         3'h5

// Result codes
`define NPD_RES_OK          8'h00
`define NPD_RES_CRC         8'h01
`define NPD_RES_SIZE        8'h02
`define NPD_RES_RANGE       8'h03
`define NPD_RES_FLASH       8'h04
`define NPD_RES_NOT_READY   8'h05
`define NPD_RES_UNKNOWN     8'h06

// Identifier ranges and identifiers named by the dispatcher
`define NPD_ID_REQUEST      8'h01
`define NPD_ID_RESTORE      8'h04
`define NPD_ID_PASS         8'h0a
`define NPD_ID_STATE_LO     8'h14
`define NPD_ID_CFG_LO       8'hb4
`define NPD_ID_EXT_PV       8'h2c
`define NPD_ID_TIMER        8'hb4
`define NPD_ID_ZERO_ALIGN   8'hc1
`define NPD_ID_PIN_OUT      8'hc3
`define NPD_ID_DUAL_ANT     8'hc4

// Length table entry layout: {known, variable, length}
`define NPD_LT_KNOWN        9
`define NPD_LT_VAR          8
`define NPD_LT_LEN_HI       7
`define NPD_LT_LEN_LO       0
`define NPD_LT_FIX          2'b10
`define NPD_LT_VARLEN       2'b11
`define NPD_LT_NONE         10'h000

// CRC16-CCITT
`define NPD_CRC_INIT        16'hffff
`define NPD_CRC_POLY        16'h1021

// Output FIFO shape
`define NPD_FIFO_W          9
`define NPD_FIFO_D          8
`define NPD_FIFO_AW         3

`endif

// ---- logic/npd_fifo.v ----
`timescale 1ns/100ps
`default_nettype none

module npd_fifo #(
    parameter W  = 9,
    parameter D  = 8,
    parameter AW = 3
) (
    input  wire         clk,       // System clock
    input  wire         resetn,    // Synchronous reset, active low
    input  wire         ce,        // Clock enable
    input  wire [W-1:0] in_data,   // Write word
    input  wire         in_valid,  // Write request
    output wire         in_ready,  // Space available
    output reg  [W-1:0] out_data,  // Registered read word
    output reg          out_valid, // Read word present
    input  wire         out_ready  // Reader takes word
);
    localparam [AW:0] DEPTH = D[AW:0];
    localparam [AW:0] ONE   = {{AW{1'b0}}, 1'b1};

    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    // Full is honest: output stage excluded, array count only
    assign in_ready = (cnt_q != DEPTH);
    assign push     = in_valid && in_ready;
    assign pop      = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    // Array write side
    always @(posedge clk) begin
        if (ce && push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers, count and registered output stage
    always @(posedge clk) begin
        if (!resetn) begin
            wr_q      <= {AW{1'b0}};
            rd_q      <= {AW{1'b0}};
            cnt_q     <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q      <= rd_q + 1'b1;
                out_data  <= mem[rd_q];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + ONE;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - ONE;
            end
        end
    end
endmodule

`default_nettype wire

// ---- logic/npd_dispatch.v ----
// Operation
// - Ack is id 0, four bytes, fixed layout
// - Ack CRC field echoes received header CRC
// - Result codes zero through six as listed
// - Wrong table length answers code two
// - Out-of-range field answers code three
// - Unknown identifier answers code six
// - Not ready gives five, flash failure four
// - Pass-through id 10 has variable length
// - External position velocity id 44, sixty bytes
// - Timer period id 180, four bytes
// - Pin output setting id 195, 33 bytes
// - Dual antenna setting id 196, 17 bytes
// - Every configuration packet gets an ack
// - External inputs acked only on failure
// - CRC16-CCITT over payload, seed all ones
`timescale 1ns/100ps
`default_nettype none
`include "npd_map.vh"

module npd_dispatch (
    input  wire        clk,         // 250 MHz system clock
    input  wire        resetn,      // Synchronous reset, active low
    input  wire        ce,          // Clock enable, freezes all state
    input  wire        hdr_valid,   // Header descriptor offered
    input  wire [7:0]  hdr_id,      // Received packet identifier
    input  wire [7:0]  hdr_len,     // Received length field
    input  wire [15:0] hdr_crc,     // Received header CRC
    output wire        hdr_ready,   // Header taken when high
    input  wire        pay_valid,   // Payload byte offered
    input  wire [7:0]  pay_data,    // Payload byte
    output wire        pay_ready,   // Payload byte taken when high
    input  wire        range_err,   // Field checker found bad value
    input  wire        not_ready,   // System cannot process yet
    input  wire        flash_fail,  // Nonvolatile store failed
    output reg         cmd_valid,   // Accepted packet pulse
    output reg  [7:0]  cmd_id,      // Accepted packet identifier
    output reg  [7:0]  cmd_len,     // Accepted packet length
    output reg  [7:0]  last_code,   // Result of the latest packet
    output reg  [15:0] ack_count,   // Acks sent
    output reg  [15:0] nak_count,   // Failure acks sent
    output wire        ack_valid,   // Ack byte offered
    output wire [7:0]  ack_data,    // Ack stream byte
    output wire        ack_last,    // Final byte of an ack
    input  wire        ack_ready    // Downstream takes byte
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_PAY  = 4'b0010;
    localparam [3:0] S_EVAL = 4'b0100;
    localparam [3:0] S_EMIT = 4'b1000;

    reg [3:0]  state_q;
    reg [3:0]  state_d;
    reg [7:0]  id_q;
    reg [7:0]  len_q;
    reg [15:0] hcrc_q;
    reg [15:0] crc_q;
    reg [7:0]  left_q;
    reg        rng_q;
    reg [7:0]  code_q;
    reg [7:0]  code_d;
    reg        send_d;
    reg [2:0]  idx_q;
    reg        hdr_rdy_q;
    reg        pay_rdy_q;
    wire       fifo_in_ready;
    wire       push;
    wire       hdr_take;
    wire       pay_take;
    wire [9:0] entry;
    wire [8:0] fifo_out;
    wire       crc_bad;
    wire       id_unknown;
    wire       len_bad;
    wire       val_bad;
    wire       last_push;
    wire [8:0] ack_word;

    // One byte of CRC16-CCITT, msb first
    function [15:0] crc_byte;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg [15:0]   r;
        begin
            r = c ^ {d, 8'h00};
            for (i = 0; i < 8; i = i + 1) begin
                if (r[15]) begin
                    r = {r[14:0], 1'b0} ^ `NPD_CRC_POLY;
                end else begin
                    r = {r[14:0], 1'b0};
                end
            end
            crc_byte = r;
        end
    endfunction

    // Receivable identifiers; output-only ones are rejected as unknown
    function [9:0] len_table;
        input [7:0] id;
        begin
            case (id)
                `NPD_ID_REQUEST:    len_table = {`NPD_LT_VARLEN, 8'h00};
                8'h02:              len_table = {`NPD_LT_FIX, 8'h01};
                `NPD_ID_RESTORE:    len_table = {`NPD_LT_FIX, 8'h04};
                8'h05:              len_table = {`NPD_LT_FIX, 8'h04};
                `NPD_ID_PASS:       len_table = {`NPD_LT_VARLEN, 8'h00};
                8'h1d:              len_table = {`NPD_LT_FIX, 8'h4a};
                `NPD_ID_EXT_PV:     len_table = {`NPD_LT_FIX, 8'h3c};
                8'h2d:              len_table = {`NPD_LT_FIX, 8'h24};
                8'h2e:              len_table = {`NPD_LT_FIX, 8'h18};
                8'h2f:              len_table = {`NPD_LT_FIX, 8'h18};
                8'h30:              len_table = {`NPD_LT_FIX, 8'h08};
                8'h35:              len_table = {`NPD_LT_FIX, 8'h08};
                8'h37:              len_table = {`NPD_LT_VARLEN, 8'h00};
                8'h38:              len_table = {`NPD_LT_FIX, 8'h08};
                8'h39:              len_table = {`NPD_LT_FIX, 8'h0c};
                8'h43:              len_table = {`NPD_LT_FIX, 8'h0d};
                8'h44:              len_table = {`NPD_LT_FIX, 8'h19};
                8'h48:              len_table = {`NPD_LT_FIX, 8'h08};
                8'h53:              len_table = {`NPD_LT_FIX, 8'h08};
                `NPD_ID_TIMER:      len_table = {`NPD_LT_FIX, 8'h04};
                8'hb5:              len_table = {`NPD_LT_VARLEN, 8'h00};
                8'hb6:              len_table = {`NPD_LT_FIX, 8'h11};
                8'hb8:              len_table = {`NPD_LT_FIX, 8'h04};
                8'hb9:              len_table = {`NPD_LT_FIX, 8'h49};
                8'hba:              len_table = {`NPD_LT_FIX, 8'h11};
                8'hbb:              len_table = {`NPD_LT_VARLEN, 8'h00};
                8'hbc:              len_table = {`NPD_LT_FIX, 8'h0d};
                8'hc0:              len_table = {`NPD_LT_FIX, 8'h08};
                `NPD_ID_ZERO_ALIGN: len_table = {`NPD_LT_FIX, 8'h05};
                8'hc2:              len_table = {`NPD_LT_FIX, 8'h31};
                `NPD_ID_PIN_OUT:    len_table = {`NPD_LT_FIX, 8'h21};
                `NPD_ID_DUAL_ANT:   len_table = {`NPD_LT_FIX, 8'h11};
                8'hc5:              len_table = {`NPD_LT_FIX, 8'h55};
                8'hc6:              len_table = {`NPD_LT_FIX, 8'h40};
                8'hc7:              len_table = {`NPD_LT_FIX, 8'h41};
                default:            len_table = `NPD_LT_NONE;
            endcase
        end
    endfunction

    // External inputs and requests stay silent on success
    function quiet_ok;
        input [7:0] id;
        begin
            quiet_ok = (id == `NPD_ID_REQUEST) ||
                       ((id >= `NPD_ID_STATE_LO) && (id < `NPD_ID_CFG_LO));
        end
    endfunction

    // Byte of the acknowledgement at a stream position
    function [7:0] ack_byte;
        input [2:0]  idx;
        input [7:0]  id;
        input [15:0] crc;
        input [7:0]  code;
        begin
            case (idx)
                `NPD_EB_ID:      ack_byte = `NPD_ACK_ID;
                `NPD_EB_LEN:     ack_byte = `NPD_ACK_LEN;
                `NPD_EB_ECHO_ID: ack_byte = id;
                `NPD_EB_CRC_LO:  ack_byte = crc[7:0];
                `NPD_EB_CRC_HI:  ack_byte = crc[15:8];
                `NPD_EB_CODE:    ack_byte = code;
                default:         ack_byte = 8'h00;
            endcase
        end
    endfunction

    assign entry     = len_table(id_q);
    assign hdr_ready = hdr_rdy_q;
    assign pay_ready = pay_rdy_q;
    assign hdr_take  = hdr_valid && hdr_rdy_q;
    assign pay_take  = pay_valid && pay_rdy_q;
    // Emission stalls on a full FIFO, so back-pressure reaches the input
    assign push      = state_q[3] && fifo_in_ready;
    assign last_push = push && (idx_q == `NPD_ACK_LAST_IDX);
    // Last-byte flag rides beside the byte through the queue
    assign ack_word  = {(idx_q == `NPD_ACK_LAST_IDX), ack_byte(idx_q, id_q, hcrc_q, code_q)};

    // Check outcomes, one wire each so the order below stays readable
    assign crc_bad    = (crc_q != hcrc_q);
    assign id_unknown = !entry[`NPD_LT_KNOWN];
    assign len_bad    = !entry[`NPD_LT_VAR] &&
                        (entry[`NPD_LT_LEN_HI:`NPD_LT_LEN_LO] != len_q);
    // Eval-cycle flag counts too, not only those seen during payload
    assign val_bad    = rng_q || range_err;

    // Verdict: first failing check wins, in fixed order
    always @* begin
        code_d = `NPD_RES_OK;
        if (crc_bad) begin
            code_d = `NPD_RES_CRC;
        end else if (id_unknown) begin
            code_d = `NPD_RES_UNKNOWN;
        end else if (len_bad) begin
            code_d = `NPD_RES_SIZE;
        end else if (val_bad) begin
            code_d = `NPD_RES_RANGE;
        end else if (not_ready) begin
            code_d = `NPD_RES_NOT_READY;
        end else if (flash_fail) begin
            code_d = `NPD_RES_FLASH;
        end
        // Configuration always acked, external inputs only on failure
        send_d = (code_d != `NPD_RES_OK) || !quiet_ok(id_q);
    end

    // Next state
    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (hdr_take) begin
                    state_d = (hdr_len == 8'h00) ? S_EVAL : S_PAY;
                end
            end
            S_PAY: begin
                if (pay_take && (left_q == 8'h01)) begin
                    state_d = S_EVAL;
                end
            end
            S_EVAL: begin
                state_d = send_d ? S_EMIT : S_IDLE;
            end
            S_EMIT: begin
                if (last_push) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Header capture, payload CRC and counters
    always @(posedge clk) begin
        if (!resetn) begin
            state_q   <= S_IDLE;
            id_q      <= 8'h00;
            len_q     <= 8'h00;
            hcrc_q    <= 16'h0000;
            crc_q     <= `NPD_CRC_INIT;
            left_q    <= 8'h00;
            rng_q     <= 1'b0;
            code_q    <= `NPD_RES_OK;
            hdr_rdy_q <= 1'b0;
            pay_rdy_q <= 1'b0;
        end else if (ce) begin
            state_q   <= state_d;
            hdr_rdy_q <= (state_d == S_IDLE);
            pay_rdy_q <= (state_d == S_PAY);
            if (hdr_take) begin
                id_q   <= hdr_id;
                len_q  <= hdr_len;
                hcrc_q <= hdr_crc;
                left_q <= hdr_len;
                crc_q  <= `NPD_CRC_INIT;
                rng_q  <= 1'b0;
            end
            if (pay_take) begin
                crc_q  <= crc_byte(crc_q, pay_data);
                left_q <= left_q - 8'h01;
            end
            // Range flag may arrive with any payload byte or at evaluation
            if (range_err && (state_q[1] || state_q[2])) begin
                rng_q <= 1'b1;
            end
            if (state_q[2]) begin
                code_q <= code_d;
            end
        end
    end

    // Ack slot index; restarts at each evaluation
    always @(posedge clk) begin
        if (!resetn) begin
            idx_q <= 3'h0;
        end else if (ce) begin
            if (state_q[2]) begin
                idx_q <= 3'h0;
            end else if (push) begin
                idx_q <= idx_q + 3'h1;
            end
        end
    end

    // Dispatch outputs and statistics
    always @(posedge clk) begin
        if (!resetn) begin
            cmd_valid <= 1'b0;
            cmd_id    <= 8'h00;
            cmd_len   <= 8'h00;
            last_code <= `NPD_RES_OK;
            ack_count <= 16'h0000;
            nak_count <= 16'h0000;
        end else if (ce) begin
            cmd_valid <= 1'b0;
            if (state_q[2]) begin
                last_code <= code_d;
                if (code_d == `NPD_RES_OK) begin
                    cmd_valid <= 1'b1;
                    cmd_id    <= id_q;
                    cmd_len   <= len_q;
                end
                // Counters wrap; software-side sampling tolerates that
                if (send_d) begin
                    ack_count <= ack_count + 16'h0001;
                end
                if (code_d != `NPD_RES_OK) begin
                    nak_count <= nak_count + 16'h0001;
                end
            end
        end
    end

    // Acks queue here so a slow serial side does not block decode at once
    npd_fifo #(
        .W  (`NPD_FIFO_W),
        .D  (`NPD_FIFO_D),
        .AW (`NPD_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_data   (ack_word),
        .in_valid  (state_q[3]),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (ack_valid),
        .out_ready (ack_ready)
    );

    assign ack_data = fifo_out[7:0];
    assign ack_last = fifo_out[8];
endmodule

`default_nettype wire

// ---- bench/npd_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module npd_checker (
    input wire logic        clk,       // System clock
    input wire logic        resetn,    // Reset, active low
    input wire logic        hdr_valid, // Header offered
    input wire logic        hdr_ready, // Header taken
    input wire logic [7:0]  hdr_len,   // Length field
    input wire logic        pay_ready, // Payload wanted
    input wire logic        cmd_valid, // Accept pulse
    input wire logic [7:0]  last_code, // Latest result
    input wire logic [15:0] ack_count, // Acks queued
    input wire logic [15:0] nak_count, // Failure acks
    input wire logic        ack_valid, // Ack byte offered
    input wire logic [7:0]  ack_data,  // Ack byte
    input wire logic        ack_last,  // Final ack byte
    input wire logic        ack_ready  // Byte taken
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [2:0] pos_q; // Slot within current ack
    // Slot count lets fixed fields be checked without knowing FIFO depth
    always @(posedge clk) begin
        if (!resetn) pos_q <= 3'h0;
        else if (ack_valid && ack_ready) pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
    end
    a_reset_idle: assert property (disable iff (1'b0)
        !resetn |=> !hdr_ready && !ack_valid && ack_count == 16'h0) else $error("not idle");
    a_ack_head: assert property (ack_valid && pos_q == 3'h0 |-> ack_data == 8'h00)
        else $error("ack id byte wrong");
    a_ack_len: assert property (ack_valid && pos_q == 3'h1 |-> ack_data == 8'h04)
        else $error("ack length byte wrong");
    a_ack_last: assert property (ack_valid |-> ack_last == (pos_q == 3'h5))
        else $error("ack last flag misplaced");
    a_code_max: assert property (ack_valid && ack_last |-> ack_data <= 8'h06)
        else $error("result code out of set");
    a_ack_hold: assert property (ack_valid && !ack_ready |=> ack_valid && $stable(ack_data))
        else $error("ack byte dropped while stalled");
    a_hdr_pay: assert property (hdr_valid && hdr_ready && hdr_len != 8'h00 |=> pay_ready)
        else $error("payload not opened");
    a_ok_pulse: assert property (cmd_valid |-> last_code == 8'h00 ##1 !cmd_valid)
        else $error("accept pulse wrong");
    a_cnt_step: assert property (ack_count != $past(ack_count) |->
        ack_count == $past(ack_count) + 16'h1) else $error("ack count jump");
    a_nak_pair: assert property ($changed(nak_count) |-> $changed(ack_count))
        else $error("failure not counted as ack");
    c_accept: cover property (cmd_valid);
    c_stall: cover property (ack_valid && !ack_ready);
    c_ack_end: cover property (ack_valid && ack_ready && ack_last);
endmodule
`default_nettype wire

// ---- bench/npd_host_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
module npd_host_sink (
    input wire logic       clk,       // System clock
    input wire logic       stall,     // Hold off the device
    input wire logic       ack_valid, // Byte offered
    input wire logic [7:0] ack_data,  // Byte value
    output logic           ack_ready, // Host takes byte
    output var logic [9:0] cnt        // Bytes received
);
    logic [7:0] buf_q [0:1023]; // Stream in arrival order
    initial cnt = 10'h0;
    // Host reads acks in order; stall from bench changes just after an edge
    assign ack_ready = !stall;
    always @(posedge clk) begin
        if (ack_valid && ack_ready) begin
            buf_q[cnt] <= ack_data;
            cnt <= cnt + 10'h1;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk, resetn, ce, hdr_valid, pay_valid, range_err, not_ready, flash_fail, stall;
    logic [7:0]  hdr_id, hdr_len, pay_data;
    logic [15:0] hdr_crc, lc, la;
    logic [9:0]  b0;
    logic [31:0] tab [0:17];
    wire         hdr_ready, pay_ready, cmd_valid, ack_valid, ack_last, ack_ready;
    wire  [7:0]  cmd_id, cmd_len, last_code, ack_data;
    wire  [15:0] ack_count, nak_count;
    wire  [9:0]  cnt;
    integer      fail_count, samples_checked, na, nn, k, n;
    npd_dispatch uut (.clk(clk), .resetn(resetn), .ce(ce), .hdr_valid(hdr_valid),
        .hdr_id(hdr_id), .hdr_len(hdr_len), .hdr_crc(hdr_crc), .hdr_ready(hdr_ready),
        .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
        .range_err(range_err), .not_ready(not_ready), .flash_fail(flash_fail),
        .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_len(cmd_len), .last_code(last_code),
        .ack_count(ack_count), .nak_count(nak_count), .ack_valid(ack_valid),
        .ack_data(ack_data), .ack_last(ack_last), .ack_ready(ack_ready));
    npd_host_sink host (.clk(clk), .stall(stall), .ack_valid(ack_valid),
        .ack_data(ack_data), .ack_ready(ack_ready), .cnt(cnt));
    // Clock at 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Reference CRC, msb first, so the bench never borrows the design's own
    function [15:0] crcb(input [15:0] c, input [7:0] d);
        integer b;
        crcb = c ^ {d, 8'h00};
        for (b = 0; b < 8; b = b + 1)
            crcb = crcb[15] ? {crcb[14:0], 1'b0} ^ 16'h1021 : {crcb[14:0], 1'b0};
    endfunction
    task results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
            fail_count = fail_count + 1;
        end
    endtask
    // One bounded clock step; a hang ends in the report
    task tick;
        @(posedge clk);
        n = n + 1;
        if (n > 300) begin
            fail_count = fail_count + 1;
            $display("[ERR] wait exp done seen timeout");
            results;
        end
    endtask
    task send(input [7:0] id, input [7:0] len, input [7:0] fl);
        logic [8:0] i;
        lc = 16'hffff;
        for (i = 0; i < len; i = i + 1) lc = crcb(lc, id + i[7:0]);
        lc = lc ^ {15'h0, fl[0]};
        @(posedge clk);
        #1 hdr_valid = 1'b1;
        {hdr_id, hdr_len, hdr_crc} = {id, len, lc};
        {flash_fail, not_ready, range_err} = fl[3:1];
        n = 0;
        do tick; while (hdr_ready !== 1'b1);
        #1 hdr_valid = 1'b0;
        for (i = 0; i < len; i = i + 1) begin
            pay_valid = 1'b1;
            pay_data = id + i[7:0];
            n = 0;
            do tick; while (pay_ready !== 1'b1);
            #1;
        end
        pay_valid = 1'b0;
    endtask
    task exp_ack(input [9:0] b, input [7:0] id, input [15:0] c, input [7:0] code);
        logic [47:0] e;
        integer j;
        e = {8'h00, 8'h04, id, c[7:0], c[15:8], code};
        for (j = 0; j < 6; j = j + 1)
            chk("ack byte", host.buf_q[b + j], e[47 - 8 * j -: 8]);
    endtask
    task drain(input [9:0] want);
        integer i;
        n = 0;
        do tick; while (hdr_ready !== 1'b1);
        i = 0;
        while (cnt !== want && i < 20) begin
            @(posedge clk);
            i = i + 1;
        end
        #1 {flash_fail, not_ready, range_err} = 3'h0;
        chk("drained", cnt, want);
    endtask
    task pkt(input [7:0] id, input [7:0] len, input [7:0] fl, input [7:0] code);
        logic [9:0] b;
        b = cnt;
        send(id, len, fl);
        drain(fl[4] ? b : b + 10'h6);
        chk("code", last_code, code);
        if (fl[4]) chk("silent", cnt, b);
        else begin
            exp_ack(b, id, lc, code);
            na = na + 1;
            if (code != 8'h00) nn = nn + 1;
        end
        if (code == 8'h00) chk("cmd", {cmd_id, cmd_len}, {id, len});
    endtask
    task cnts;
        chk("acks", ack_count, na[15:0]);
        chk("naks", nak_count, nn[15:0]);
    endtask
    initial begin
        {ce, resetn, hdr_valid, pay_valid, range_err, not_ready, flash_fail, stall} = 8'h80;
        {hdr_id, hdr_len, hdr_crc, pay_data} = 40'h0;
        {fail_count, samples_checked, na, nn} = 128'h0;
        // Rows: id, length, flags {silent, flash, busy, range, bad crc}, code
        tab[0] = 32'hb4040000; tab[1] = 32'hc3210000; tab[2] = 32'hc4110000;
        tab[3] = 32'h04040000; tab[4] = 32'hc1050000; tab[5] = 32'h0a030000;
        tab[6] = 32'h2c3c1000; tab[7] = 32'h2c3b0002; tab[8] = 32'hb4050002;
        tab[9] = 32'hb4040101; tab[10] = 32'h03180006; tab[11] = 32'hc8000006;
        tab[12] = 32'hb4040203; tab[13] = 32'hb4040405; tab[14] = 32'hb4040804;
        tab[15] = 32'h03180101; tab[16] = 32'h2c3b0202;
        tab[17] = 32'h0a000203;
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        for (k = 0; k < 18; k = k + 1) begin
            pkt(tab[k][31:24], tab[k][23:16], tab[k][15:8], tab[k][7:0]);
            $display("test %0d done", k);
        end
        // Stalled host: FIFO fills, second ack stalls, header gate stays shut
        #1 stall = 1'b1;
        b0 = cnt;
        send(8'hb4, 8'h04, 8'h00);
        la = lc;
        drain(b0);
        send(8'hc4, 8'h11, 8'h02);
        repeat (30) @(posedge clk);
        #1 chk("gate shut", {hdr_ready, ack_valid, cnt}, {2'b01, b0});
        stall = 1'b0;
        drain(b0 + 10'hc);
        exp_ack(b0, 8'hb4, la, 8'h00);
        exp_ack(b0 + 10'h6, 8'hc4, lc, 8'h03);
        na = na + 2;
        nn = nn + 1;
        cnts;
        $display("test fifo done");
        // Reset in mid-run clears status and counts
        @(posedge clk);
        #1 resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("reset", {hdr_ready, ack_valid, cmd_valid, last_code}, 16'h0);
        chk("reset cnt", ack_count | nak_count, 16'h0);
        resetn = 1'b1;
        @(posedge clk);
        #1 chk("ready after reset", hdr_ready, 1'b1);
        {na, nn} = 64'h0;
        pkt(8'hb4, 8'h04, 8'h04, 8'h05);
        cnts;
        $display("test reset done");
        results;
    end
endmodule
bind npd_dispatch npd_checker chk_i (.clk(clk), .resetn(resetn), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr_len(hdr_len), .pay_ready(pay_ready), .cmd_valid(cmd_valid),
    .last_code(last_code), .ack_count(ack_count), .nak_count(nak_count),
    .ack_valid(ack_valid), .ack_data(ack_data), .ack_last(ack_last), .ack_ready(ack_ready));
`default_nettype wire
